// File: src/epo_dfc.sv
// Digital-to-frequency converter: accumulates a magnitude per sample and
// emits a fixed-width pulse each time the accumulator passes a threshold.
// Assumes ACC_W is wide enough to hold THRESH plus one full-scale magnitude.
`timescale 1ns/10ps
module epo_dfc #(
	parameter int               MAG_W  = 26,
	parameter int               ACC_W  = 32,
	parameter logic [ACC_W-1:0] THRESH = 32'h0100_0000
) (
	input  wire logic             mclk,
	input  wire logic             srst,
	input  wire logic             sample_en,
	input  wire logic [MAG_W-1:0] mag,
	output logic                  pulse
);
	typedef struct packed {
		logic [ACC_W-1:0]          acc;
		logic [epo_pkg::WCNT_W-1:0] wcnt;
		logic                      pulse;
	} epo_dfc_s;

	epo_dfc_s s_r;
	epo_dfc_s s_nxt;
	logic [ACC_W:0] sum;

	always_comb begin
		s_nxt = s_r;
		sum   = {1'h0, s_r.acc} + (ACC_W + 1)'(mag);
		if (s_r.pulse) begin
			if (s_r.wcnt == '0)
				s_nxt.pulse = 1'h0;
			else
				s_nxt.wcnt = s_r.wcnt - 1'h1;
		end
		if (sample_en) begin
			if (sum >= {1'h0, THRESH}) begin
				s_nxt.acc   = ACC_W'(sum - {1'h0, THRESH});
				s_nxt.pulse = 1'h1;
				s_nxt.wcnt  = epo_pkg::WCNT_W'(epo_pkg::PULSE_CYC - 1);
			end else begin
				s_nxt.acc = sum[ACC_W-1:0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign pulse = s_r.pulse;
endmodule

// File: src/epo_pkg.sv
// Constants and carrier types for the energy pulse output select block.
// Assumes a single 125 MHz clock; all inputs come from logic on that clock.
package epo_pkg;
	// Clock and timing
	localparam int CLK_NS     = 8;
	localparam int PULSE_NS   = 80;
	localparam int PULSE_CYC  = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SAMPLE_DIV = 125;
	localparam int DIV_W      = 8;
	localparam int WCNT_W     = 8;

	// Power widths
	localparam int P_W = 24;
	localparam int S_W = P_W + 2;

	// Configuration word layout
	localparam int CFG_W   = 16;
	localparam int SEL_LSB = 6;
	localparam int DIS_BIT = 9;
	localparam int INC_LSB = 6;

	// Source selector codes
	localparam logic [2:0] SEL_APPARENT = 3'h2;
	localparam logic [2:0] SEL_FACT     = 3'h3;
	localparam logic [2:0] SEL_FREACT   = 3'h4;

	// Reset values
	localparam logic [2:0] SEL_RST = SEL_APPARENT;
	localparam logic       DIS_RST = 1'h1;
	localparam logic [2:0] INC_RST = 3'h7;

	typedef struct packed {
		logic       dis;
		logic [2:0] sel;
		logic [2:0] inc;
	} epo_cfg_s;

	typedef struct packed {
		logic signed [P_W-1:0] a;
		logic signed [P_W-1:0] b;
		logic signed [P_W-1:0] c;
	} epo_phase_s;
endpackage

// File: src/epo_top.sv
// Pulse output configuration: source selection and phase summing for the
// third pulse output, pin gating for the first pulse output.
// Assumes config writes and power samples arrive on mclk, already in domain.
`timescale 1ns/10ps
// What this block does
// - Codes 010, 011, 100 feed the third output from apparent, fund active, fund reactive sums.
// - The sum only includes phases whose bit is set in bits 8:6 of the computation mode word.
// - On variants without fundamental measurement, a fundamental selector code has no effect.
// - With the first output disable bit at 1 the first pulse pin stays inactive.
// - The first output converter keeps running while its pin is disabled.
// - The disable bit is bit 9 and resets to 1; the selector resets to 010.
// - Reserved selector codes 101 to 111 produce no signal on the third pulse output.
// - With the disable bit at 0 the converter pulses reach the first pulse pin.
module epo_top #(
	parameter bit                 HAS_FUND = 1'h1,
	parameter logic [31:0]        THRESH1  = 32'h0100_0000,
	parameter logic [31:0]        THRESH3  = 32'h0100_0000
) (
	input  wire logic                           mclk,
	input  wire logic                           srst,
	input  wire logic                           pulse_cfg_wr,
	input  wire logic [epo_pkg::CFG_W-1:0]      pulse_cfg_word,
	input  wire logic                           comp_mode_wr,
	input  wire logic [epo_pkg::CFG_W-1:0]      computation_mode_register,
	input  wire logic signed [epo_pkg::S_W-1:0] pulse1_power,
	input  wire epo_pkg::epo_phase_s            apparent_power,
	input  wire epo_pkg::epo_phase_s            fund_active_power,
	input  wire epo_pkg::epo_phase_s            fund_reactive_power,
	output logic                                pulse_output_one,
	output logic                                pulse_output_three,
	output epo_pkg::epo_cfg_s                   cfg_status
);
	localparam int S_W   = epo_pkg::S_W;
	localparam int ACC_W = $bits(THRESH1);

	typedef struct packed {
		epo_pkg::epo_cfg_s         cfg;
		logic [epo_pkg::DIV_W-1:0] div;
		logic                      sample_en;
		logic                      out1;
		logic                      out3;
	} epo_state_s;

	epo_state_s             s_r;
	epo_state_s             s_nxt;
	logic signed [S_W-1:0]  app_sum;
	logic signed [S_W-1:0]  fact_sum;
	logic signed [S_W-1:0]  freact_sum;
	logic signed [S_W-1:0]  p3_sum;
	logic                   p3_live;
	logic [S_W-1:0]         p1_mag;
	logic [S_W-1:0]         p3_mag;
	logic                   dfc1_pulse;
	logic                   dfc3_pulse;
	logic [2:0]             wr_sel;
	logic                   wr_fund;

	function automatic logic signed [S_W-1:0] sum3(input epo_pkg::epo_phase_s p,
		input logic [2:0] inc);
		logic signed [S_W-1:0] acc;
		acc = '0;
		if (inc[0])
			acc = acc + S_W'(p.a);
		if (inc[1])
			acc = acc + S_W'(p.b);
		if (inc[2])
			acc = acc + S_W'(p.c);
		return acc;
	endfunction

	function automatic logic [S_W-1:0] mag_of(input logic signed [S_W-1:0] v);
		return v[S_W-1] ? S_W'(-v) : S_W'(v);
	endfunction

	always_comb begin
		app_sum    = sum3(apparent_power, s_r.cfg.inc);
		fact_sum   = sum3(fund_active_power, s_r.cfg.inc);
		freact_sum = sum3(fund_reactive_power, s_r.cfg.inc);
		p3_live    = 1'h1;
		unique case (s_r.cfg.sel)
			epo_pkg::SEL_APPARENT: p3_sum = app_sum;
			epo_pkg::SEL_FACT:     p3_sum = fact_sum;
			epo_pkg::SEL_FREACT:   p3_sum = freact_sum;
			default: begin
				// Reserved and unsupported codes starve the converter
				p3_sum  = '0;
				p3_live = 1'h0;
			end
		endcase
		p3_mag = mag_of(p3_sum);
		// Not gated by the disable bit, so the count keeps its phase
		p1_mag = mag_of(pulse1_power);
	end

	always_comb begin
		s_nxt   = s_r;
		wr_sel  = pulse_cfg_word[epo_pkg::SEL_LSB +: 3];
		wr_fund = (wr_sel == epo_pkg::SEL_FACT) || (wr_sel == epo_pkg::SEL_FREACT);
		if (pulse_cfg_wr) begin
			s_nxt.cfg.dis = pulse_cfg_word[epo_pkg::DIS_BIT];
			// Fundamental codes are dropped on parts without that path
			if (HAS_FUND || !wr_fund)
				s_nxt.cfg.sel = wr_sel;
		end
		if (comp_mode_wr)
			s_nxt.cfg.inc = computation_mode_register[epo_pkg::INC_LSB +: 3];
		if (s_r.div == epo_pkg::DIV_W'(epo_pkg::SAMPLE_DIV - 1)) begin
			s_nxt.div       = '0;
			s_nxt.sample_en = 1'h1;
		end else begin
			s_nxt.div       = s_r.div + 1'h1;
			s_nxt.sample_en = 1'h0;
		end
		s_nxt.out1 = dfc1_pulse & ~s_r.cfg.dis;
		s_nxt.out3 = dfc3_pulse & p3_live;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			s_r         <= '0;
			s_r.cfg.dis <= epo_pkg::DIS_RST;
			s_r.cfg.sel <= epo_pkg::SEL_RST;
			s_r.cfg.inc <= epo_pkg::INC_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	epo_dfc #(
		.MAG_W  (S_W),
		.ACC_W  (ACC_W),
		.THRESH (THRESH1)
	) u_dfc1 (
		.mclk      (mclk),
		.srst      (srst),
		.sample_en (s_r.sample_en),
		.mag       (p1_mag),
		.pulse     (dfc1_pulse)
	);

	epo_dfc #(
		.MAG_W  (S_W),
		.ACC_W  (ACC_W),
		.THRESH (THRESH3)
	) u_dfc3 (
		.mclk      (mclk),
		.srst      (srst),
		.sample_en (s_r.sample_en),
		.mag       (p3_mag),
		.pulse     (dfc3_pulse)
	);

	assign pulse_output_one   = s_r.out1;
	assign pulse_output_three = s_r.out3;
	assign cfg_status         = s_r.cfg;

	property p_reset_values;
		@(posedge mclk) srst |=> (cfg_status.dis == epo_pkg::DIS_RST)
			&& (cfg_status.sel == epo_pkg::SEL_RST);
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("bad reset config");

	property p_out1_off;
		@(posedge mclk) disable iff (srst) s_r.cfg.dis |=> !pulse_output_one;
	endproperty
	a_out1_off: assert property (p_out1_off) else $error("pulse one active while off");

	property p_out1_on;
		@(posedge mclk) disable iff (srst)
			!s_r.cfg.dis |=> (pulse_output_one == $past(dfc1_pulse));
	endproperty
	a_out1_on: assert property (p_out1_on) else $error("pulse one not passed");

	property p_dfc_runs;
		@(posedge mclk) disable iff (srst)
			s_r.cfg.dis && s_r.sample_en && (ACC_W'(p1_mag) >= THRESH1) |-> ##[1:2] dfc1_pulse;
	endproperty
	a_dfc_runs: assert property (p_dfc_runs) else $error("converter stopped");

	property p_reserved;
		@(posedge mclk) disable iff (srst)
			(s_r.cfg.sel > epo_pkg::SEL_FREACT) [*2] |-> !pulse_output_three;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code drives out3");

	property p_select;
		@(posedge mclk) disable iff (srst)
			(s_r.cfg.sel == epo_pkg::SEL_FACT) |-> (p3_mag == mag_of(fact_sum))
				&& p3_live ##1 (pulse_output_three == $past(dfc3_pulse));
	endproperty
	a_select: assert property (p_select) else $error("wrong source for out3");

	property p_no_phase;
		@(posedge mclk) disable iff (srst)
			$past(comp_mode_wr)
				&& ($past(computation_mode_register[epo_pkg::INC_LSB +: 3]) == 3'h0)
				|-> (app_sum == '0) && (freact_sum == '0);
	endproperty
	a_no_phase: assert property (p_no_phase) else $error("excluded phase summed");

	property p_fund_blocked;
		@(posedge mclk) disable iff (srst)
			!HAS_FUND && pulse_cfg_wr && wr_fund |=> (cfg_status.sel == $past(s_r.cfg.sel));
	endproperty
	a_fund_blocked: assert property (p_fund_blocked) else $error("fund code taken");

	c_out1: cover property (@(posedge mclk) disable iff (srst) $rose(pulse_output_one));
	c_out3: cover property (@(posedge mclk) disable iff (srst) $rose(pulse_output_three));
	c_gated: cover property (@(posedge mclk) disable iff (srst) s_r.cfg.dis && dfc1_pulse);
	c_resv: cover property (@(posedge mclk) disable iff (srst) s_r.cfg.sel == 3'h5);
endmodule

// File: verif/epo_tb.sv
// Self-checking bench for the pulse output select block, both variants.
// Assumes the package and design files are compiled first.
`timescale 1ns/10ps
module testbench;
	localparam logic [31:0]       THR = 32'h0000_0100;
	// Exactly one threshold per tick, so no charge is left between scenarios
	localparam logic signed [23:0] BIG = 24'(THR);
	logic                              mclk;
	logic                              srst;
	logic                              cfg_wr;
	logic                              cm_wr;
	logic [epo_pkg::CFG_W-1:0]         cfg_word;
	logic [epo_pkg::CFG_W-1:0]         cm_word;
	logic signed [epo_pkg::S_W-1:0]    p1;
	epo_pkg::epo_phase_s               app;
	epo_pkg::epo_phase_s               fact;
	epo_pkg::epo_phase_s               frea;
	logic                              pin1;
	logic                              pin3;
	logic                              pin1_nf;
	logic                              pin3_nf;
	epo_pkg::epo_cfg_s                 st;
	epo_pkg::epo_cfg_s                 st_nf;
	int                                error_cnt;
	int                                checks;
	logic                              s1;
	logic                              s3;
	logic                              s1n;
	logic                              s3n;

	epo_top #(.HAS_FUND(1'h1), .THRESH1(THR), .THRESH3(THR)) u_epo_top (
		.mclk(mclk), .srst(srst), .pulse_cfg_wr(cfg_wr), .pulse_cfg_word(cfg_word),
		.comp_mode_wr(cm_wr), .computation_mode_register(cm_word), .pulse1_power(p1),
		.apparent_power(app), .fund_active_power(fact), .fund_reactive_power(frea),
		.pulse_output_one(pin1), .pulse_output_three(pin3), .cfg_status(st));
	// Reduced variant without the fundamental path
	epo_top #(.HAS_FUND(1'h0), .THRESH1(THR), .THRESH3(THR)) u_epo_top_nf (
		.mclk(mclk), .srst(srst), .pulse_cfg_wr(cfg_wr), .pulse_cfg_word(cfg_word),
		.comp_mode_wr(cm_wr), .computation_mode_register(cm_word), .pulse1_power(p1),
		.apparent_power(app), .fund_active_power(fact), .fund_reactive_power(frea),
		.pulse_output_one(pin1_nf), .pulse_output_three(pin3_nf), .cfg_status(st_nf));

	initial begin
		mclk = 1'h0;
		forever #4 mclk = ~mclk;
	end

	task chk(input logic ok, input string msg);
		checks++;
		if (ok !== 1'h1) begin
			error_cnt++;
			$display("MISMATCH at %0t: %s", $time, msg);
		end
	endtask

	task wr_cfg(input logic dis, input logic [2:0] sel);
		@(posedge mclk);
		cfg_wr   <= 1'h1;
		cfg_word <= {6'h00, dis, sel, 6'h00};
		@(posedge mclk);
		cfg_wr <= 1'h0;
		#1;
	endtask

	task wr_inc(input logic [2:0] inc);
		@(posedge mclk);
		cm_wr   <= 1'h1;
		cm_word <= {7'h00, inc, 6'h00};
		@(posedge mclk);
		cm_wr <= 1'h0;
	endtask

	// Skip a standing pulse first, so only fresh pulses count
	task watch(input int n);
		repeat (12) @(posedge mclk);
		s1  = 1'h0;
		s3  = 1'h0;
		s1n = 1'h0;
		s3n = 1'h0;
		repeat (n) begin
			@(posedge mclk);
			#1;
			if (pin1 === 1'h1) s1 = 1'h1;
			if (pin3 === 1'h1) s3 = 1'h1;
			if (pin1_nf === 1'h1) s1n = 1'h1;
			if (pin3_nf === 1'h1) s3n = 1'h1;
		end
	endtask

	task t_reset;
		chk(st.dis === 1'h1 && st.sel === 3'h2 && st.inc === 3'h7, "reset config");
		chk(pin1 === 1'h0 && pin3 === 1'h0, "pins after reset");
		watch(300);
		chk(s1 === 1'h0, "pin one pulsed while disabled");
		$display("test reset done");
	endtask

	task t_select;
		logic [2:0] nf_sel;
		nf_sel = 3'h2;
		for (int src = 0; src < 3; src++) begin
			@(posedge mclk);
			app  <= '{a: (src == 0) ? BIG : '0, b: '0, c: '0};
			fact <= '{a: (src == 1) ? BIG : '0, b: '0, c: '0};
			frea <= '{a: (src == 2) ? BIG : '0, b: '0, c: '0};
			for (int c = 2; c < 8; c++) begin
				wr_cfg(1'h1, 3'(c));
				chk(st.sel === 3'(c), "selector not loaded");
				if (c != 3 && c != 4) nf_sel = 3'(c);
				chk(st_nf.sel === nf_sel, "reduced variant selector");
				watch(260);
				chk(s3 === 1'(c == src + 2), "third pin source");
				chk(s3n === 1'(nf_sel == src + 2), "reduced variant third pin");
				chk(s1 === 1'h0, "pin one pulsed while disabled");
			end
		end
		$display("test select done");
	endtask

	task t_phase;
		wr_cfg(1'h1, 3'h2);
		for (int ph = 0; ph < 3; ph++) begin
			@(posedge mclk);
			app <= '{a: (ph == 0) ? BIG : '0, b: (ph == 1) ? BIG : '0, c: (ph == 2) ? BIG : '0};
			for (int k = 0; k < 3; k++) begin
				wr_inc(3'(1 << k));
				watch(260);
				chk(s3 === 1'(k == ph), "phase inclusion");
			end
		end
		wr_inc(3'h0);
		watch(260);
		chk(s3 === 1'h0, "pulse with no phase included");
		$display("test phase done");
	endtask

	// Converter kept running while gated, so pulses show within one tick
	task t_enable;
		wr_cfg(1'h0, 3'h2);
		watch(130);
		chk(s1 === 1'h1, "pin one silent when enabled");
		chk(s1n === 1'h1, "reduced variant pin one silent");
		wr_cfg(1'h1, 3'h2);
		watch(260);
		chk(s1 === 1'h0, "pin one pulsed after disable");
		$display("test enable done");
	endtask

	// Charge the first converter while its pin is gated; the pulse falls due after enable
	task t_keep;
		int n;
		wr_cfg(1'h0, 3'h2);
		repeat (12) @(posedge mclk);
		#1;
		n = 0;
		while (pin1 !== 1'h0 && n < 20) begin
			@(posedge mclk);
			#1;
			n++;
		end
		while (pin1 !== 1'h1 && n < 200) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk(n < 200, "no pulse to align to");
		// Pin rose one edge after a tick; the next ticks are 124 and 249 edges on
		wr_cfg(1'h1, 3'h2);
		@(posedge mclk);
		p1 <= 26'(THR * 3 / 4);
		repeat (130) @(posedge mclk);
		p1 <= 26'(THR / 4);
		wr_cfg(1'h0, 3'h2);
		watch(130);
		chk(s1 === 1'h1, "charge lost while gated");
		$display("test keep done");
	endtask

	task print_verdict;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		error_cnt = 0;
		checks    = 0;
		srst      = 1'h1;
		cfg_wr    = 1'h0;
		cm_wr     = 1'h0;
		cfg_word  = '0;
		cm_word   = '0;
		p1        = 26'(BIG);
		app       = '0;
		fact      = '0;
		frea      = '0;
		repeat (5) @(posedge mclk);
		srst <= 1'h0;
		@(posedge mclk);
		#1;
		t_reset();
		t_select();
		t_phase();
		t_enable();
		t_keep();
		print_verdict();
	end
endmodule
